// ==== common/reset_seq_pkg.sv ====
// Purpose: shared constants and types for the reset and calibration sequencer
// Assumes: 100 MHz ref_clk
// Notes:   times kept in ns, cycle counts derived from them
package reset_seq_pkg;
  localparam int  CLK_PERIOD_NS  = 10;
  localparam int  RST_TIME_NS    = 100000;
  localparam int  RST_TIMER_CYC  = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  PRESET_COUNT   = 32;
  localparam int  PRESET_W       = 5;
  localparam int  ADDR_SEL_COUNT = 4;
  localparam int  ADDR_SEL_W     = 2;
  localparam logic [1:0] IFSEL_SPI = 2'h0;
  localparam logic [1:0] IFSEL_I2C = 2'h1;
  localparam logic [1:0] IFSEL_PIN = 2'h2;
  localparam logic [6:0] I2C_ADDR_BASE = 7'h54;

  typedef enum {
    ST_RESET,
    ST_STABILIZE,
    ST_CALIBRATE,
    ST_RUN
  } seq_state_t;

  // configuration source requests towards the register bank
  typedef struct packed {
    logic                load_defaults;
    logic                use_pin_preset;
    logic [PRESET_W-1:0] preset;
  } cfg_ctrl_t;

  typedef struct packed {
    logic outputs_reset;
    logic outputs_enabled;
    logic cal_start;
  } out_ctrl_t;
endpackage

// ==== rtl/reset_cal_sequencer.sv ====
// Purpose: reset, default load and VCO calibration sequencing for a clock generator
// Assumes: pin inputs synchronous to ref_clk; calibration engine answers with calDone
// Notes:   soft reset is the falling edge of the soft-reset bit (high then low)
`timescale 1ns/1ns
// Functional notes
// - normal operation only while power-down and hard reset inputs are both high.
// - either input low enters reset and holds it while low.
// - reset exits automatically at power-up or when a pin returns high.
// - pin or power reset exit reloads all register defaults.
// - soft reset keeps frequency plan; calibration uses current register values.
// - soft-reset bit rests low; write high then low triggers reset.
// - after exit, start timer; calibrate only when supplies good and timer expired.
// - all clock outputs held in reset throughout calibration.
// - calibration follows both pin/power reset and soft reset.
// - in pin mode, control pins set configuration in every state.
// - in host mode registers start at defaults, then host writes them.
// - mode change by select pins then power-down pulse; outputs off during load.
// - in pin mode the shared pin is an active power input, pulled high.
// - hard reset held from power-up keeps outputs off; calibrate after release.
// - thirty-two pin-mode preset configurations without serial programming.
// - I2C target address selectable among four values.
// - select pins at binary 10 choose pin-mode preset configuration.
module reset_cal_sequencer
  import reset_seq_pkg::*;
#(
  parameter int RST_CYCLES = RST_TIMER_CYC
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // host pins
  input  wire logic                     power_down_input_n,
  input  wire logic                     hard_reset_input_n,
  input  wire logic                     pin_mode_power_input,
  input  wire logic [1:0]               ifSelect,
  input  wire logic [PRESET_W-1:0]      presetPins,
  input  wire logic [ADDR_SEL_W-1:0]    addrSelPins,
  // register bank side
  input  wire logic                     softResetBit,
  output reset_seq_pkg::cfg_ctrl_t      cfgCtrl,
  output logic [6:0]                    i2cAddress,
  // analog side
  input  wire logic                     suppliesGood,
  input  wire logic                     calDone,
  output reset_seq_pkg::out_ctrl_t      outCtrl,
  output reset_seq_pkg::seq_state_t     seqState
);
  import reset_seq_pkg::*;

  seq_state_t          state_reg, state_next;
  logic [31:0]         timer_reg, timer_next;
  logic                softBit_reg;
  logic                pinReset_reg;
  logic                pinMode_reg;
  logic [PRESET_W-1:0] preset_reg;
  logic [6:0]          addr_reg;
  cfg_ctrl_t           cfg_reg;
  out_ctrl_t           out_reg;

  // pin mode: the shared pin acts as an extra power-down, pulled high outside
  wire pinModeSel  = (ifSelect == IFSEL_PIN);
  wire powerOk     = pinModeSel ? pin_mode_power_input : 1'b1;
  wire pinReset    = !power_down_input_n || !hard_reset_input_n || !powerOk;
  wire pinResetRel = pinReset_reg && !pinReset;
  wire softReset   = softBit_reg && !softResetBit && !pinReset;
  wire timerDone   = (timer_reg >= 32'(RST_CYCLES));
  wire calGo       = timerDone && suppliesGood;

  always_comb begin
    state_next = state_reg;
    timer_next = timer_reg;
    if (pinReset) begin
      state_next = ST_RESET;
      timer_next = '0;
    end else if (softReset || (state_reg == ST_RESET)) begin
      state_next = ST_STABILIZE;
      timer_next = '0;
    end else begin
      case (state_reg)
        ST_STABILIZE: begin
          if (!timerDone) timer_next = timer_reg + 32'h1;
          if (calGo) state_next = ST_CALIBRATE;
        end
        ST_CALIBRATE: begin
          if (calDone) state_next = ST_RUN;
        end
        ST_RUN: state_next = ST_RUN;
        default: state_next = ST_RESET;
      endcase
    end
  end

  // pin mode follows the pins live; host mode uses preset_reg, which copies the pins every cycle
  wire usePreset = pinMode_reg;
  wire [PRESET_W-1:0] presetNow = usePreset ? presetPins : preset_reg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg    <= ST_RESET;
      timer_reg    <= '0;
      softBit_reg  <= 1'b0;
      pinReset_reg <= 1'b1;
      pinMode_reg  <= 1'b0;
      preset_reg   <= '0;
      addr_reg     <= I2C_ADDR_BASE;
      cfg_reg      <= '0;
      out_reg      <= '0;
    end else begin
      state_reg    <= state_next;
      timer_reg    <= timer_next;
      softBit_reg  <= softResetBit;
      pinReset_reg <= pinReset;
      if (pinReset) begin
        // mode and address are taken while the device sits in reset
        pinMode_reg <= pinModeSel;
        addr_reg    <= I2C_ADDR_BASE | {5'h0, addrSelPins};
      end
      preset_reg <= presetPins;
      // defaults reload on pin exit only, never on soft reset
      cfg_reg.load_defaults  <= pinResetRel;
      cfg_reg.use_pin_preset <= usePreset;
      cfg_reg.preset         <= presetNow;
      out_reg.outputs_reset   <= (state_next != ST_RUN);
      out_reg.outputs_enabled <= (state_next == ST_RUN);
      out_reg.cal_start       <= (state_reg == ST_STABILIZE) && (state_next == ST_CALIBRATE);
    end
  end

  // soft reset leaves cfgCtrl untouched, so calibration uses live registers
  assign cfgCtrl    = cfg_reg;
  assign outCtrl    = out_reg;
  assign seqState   = state_reg;
  assign i2cAddress = addr_reg;

  a_reset_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pinReset |=> (state_reg == ST_RESET))
    else $error("reset pin low but sequencer not in reset");
  a_reset_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RESET) && !pinReset |=> (state_reg == ST_STABILIZE))
    else $error("no automatic exit from reset");
  a_defaults_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pinResetRel |=> cfgCtrl.load_defaults)
    else $error("defaults not reloaded on pin release");
  a_soft_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
    softReset && !pinReset_reg |=> !cfgCtrl.load_defaults)
    else $error("soft reset reloaded defaults");
  a_soft_restart: assert property (@(posedge ref_clk) disable iff (!rst_n)
    softReset |=> (state_reg == ST_STABILIZE) && (timer_reg == 0))
    else $error("soft reset did not restart sequence");
  a_cal_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_STABILIZE) && $past(state_reg) == ST_STABILIZE && !calGo
      && !pinReset && !softReset |=> (state_reg == ST_STABILIZE))
    else $error("calibration started early");
  a_cal_outputs: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_CALIBRATE) |-> outCtrl.outputs_reset && !outCtrl.outputs_enabled)
    else $error("outputs live during calibration");
  a_release_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(outCtrl.outputs_enabled) |-> (state_reg == ST_RUN) && $past(calDone))
    else $error("outputs released without calibration done");
  a_normal_pins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    outCtrl.outputs_enabled |-> $past(power_down_input_n) && $past(hard_reset_input_n))
    else $error("outputs on while a reset pin was low");
  a_pin_preset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pinMode_reg && $past(pinMode_reg) |-> cfgCtrl.preset == $past(presetPins))
    else $error("pin-mode preset not following pins");

  // reset state: outputs stay dark and no calibration may start
  // a pin held low must win over any sequencing already under way
  a_reset_outs_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RESET) |-> !outCtrl.outputs_enabled && !outCtrl.cal_start)
    else $error("outputs or calibration active in reset");

  a_held_reset_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !hard_reset_input_n |=> !outCtrl.outputs_enabled)
    else $error("outputs on while hard reset held low");

  a_pdn_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !power_down_input_n |=> !outCtrl.outputs_enabled)
    else $error("outputs on while power-down held low");

  a_pin_power: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pinModeSel && !pin_mode_power_input |=> (state_reg == ST_RESET))
    else $error("pin-mode power input low did not reset");

  // outside pin mode the shared pin is a don't-care
  a_power_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pinModeSel && power_down_input_n && hard_reset_input_n && !softReset
      && (state_reg == ST_RUN) |=> (state_reg == ST_RUN))
    else $error("shared pin acted outside pin mode");

  // stabilization: timer restarts from zero and gates calibration
  // the timer saturates so a long supply wait cannot wrap it
  a_stab_outs_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_STABILIZE) |-> outCtrl.outputs_reset && !outCtrl.outputs_enabled)
    else $error("outputs live while stabilizing");

  a_timer_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RESET) && !pinReset |=> (timer_reg == 0))
    else $error("timer not restarted on reset exit");

  a_stab_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RESET) ##1 (state_reg == ST_STABILIZE) |-> (timer_reg == 0))
    else $error("stabilization entered with stale timer");

  a_timer_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    timer_reg <= 32'(RST_CYCLES))
    else $error("reset timer ran past its length");

  a_cal_needs_timer: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_STABILIZE) ##1 (state_reg == ST_CALIBRATE)
      |-> $past(suppliesGood) && ($past(timer_reg) >= 32'(RST_CYCLES)))
    else $error("calibration began before supplies and timer");

  // calibration handshake: one start pulse, outputs held until done
  a_cal_start_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
    outCtrl.cal_start |-> (state_reg == ST_CALIBRATE))
    else $error("calibration start outside calibrate state");

  a_cal_start_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    outCtrl.cal_start |=> !outCtrl.cal_start)
    else $error("calibration start longer than one cycle");

  a_cal_waits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_CALIBRATE) && !calDone && !pinReset && !softReset
      |=> (state_reg == ST_CALIBRATE))
    else $error("calibration left without done");

  a_run_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_CALIBRATE) ##1 (state_reg == ST_RUN) |-> $past(calDone))
    else $error("run entered without calibration done");

  // a reset arriving mid-calibration must keep the outputs dark
  a_cal_abort: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_CALIBRATE) && pinReset |=> !outCtrl.outputs_enabled)
    else $error("outputs released after reset during calibration");

  // normal operation: sticky until a pin or soft reset
  a_run_outs_on: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RUN) |-> outCtrl.outputs_enabled && !outCtrl.outputs_reset)
    else $error("outputs not released in run");

  a_run_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == ST_RUN) && !pinReset && !softReset |=> (state_reg == ST_RUN))
    else $error("run left without a reset");

  // soft-reset bit: only its fall counts, and only outside pin reset
  a_soft_rest_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !softBit_reg && !softResetBit && !pinReset && (state_reg == ST_RUN)
      |=> (state_reg == ST_RUN))
    else $error("resting soft-reset bit disturbed run");

  a_soft_in_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pinReset && softBit_reg && !softResetBit |=> (state_reg == ST_RESET))
    else $error("soft reset overrode pin reset");

  // register defaults: one pulse per pin exit, none otherwise
  a_no_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pinReset_reg |=> !cfgCtrl.load_defaults)
    else $error("defaults reloaded without pin exit");

  a_defaults_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfgCtrl.load_defaults |=> !cfgCtrl.load_defaults)
    else $error("default load longer than one cycle");

  // mode and address: latched in reset only, live pins ignored later
  // changing select pins in run moves the mode at the next pin reset; the shared power pin gating follows them at once
  a_mode_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pinReset |=> $stable(pinMode_reg))
    else $error("interface mode changed outside reset");

  a_preset_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cfgCtrl.use_pin_preset == $past(pinMode_reg))
    else $error("preset source flag disagrees with mode");

  a_addr_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pinReset |=> $stable(i2cAddress))
    else $error("serial address changed outside reset");

  a_addr_base: assert property (@(posedge ref_clk) disable iff (!rst_n)
    i2cAddress[6:2] == I2C_ADDR_BASE[6:2])
    else $error("serial address upper bits wrong");

  a_addr_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pinReset |=> (i2cAddress == (I2C_ADDR_BASE | {5'h0, $past(addrSelPins)})))
    else $error("serial address not taken from select pins");
endmodule // reset_cal_sequencer

// ==== test/cal_engine_model.sv ====
// Purpose: behavioural calibration engine answering the sequencer
// Assumes: calStart is a one-cycle pulse
// Notes:   answer delay set by the bench, prompt (0) up to slow (15)
`timescale 1ns/1ns
module cal_engine_model (
  // clock and abort
  input  wire logic       ref_clk,
  input  wire logic       abort,
  // handshake
  input  wire logic       calStart,
  input  wire logic [3:0] calDelay,
  output logic            calDone
);
  logic [3:0] cnt_reg;
  logic       busy_reg;
  always_ff @(posedge ref_clk) begin
    if (abort) begin
      busy_reg <= 1'b0;
    end else if (calStart) begin
      busy_reg <= 1'b1;
      cnt_reg  <= calDelay;
    end else if (busy_reg && cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else begin
      busy_reg <= 1'b0;
    end
  end
  // done lasts one cycle so a stale answer never leaks into the next run
  assign calDone = busy_reg && cnt_reg == 4'h0;
endmodule // cal_engine_model

// ==== test/tb_reset_cal_sequencer.sv ====
// Purpose: self-checking bench for the reset and calibration sequencer
// Assumes: RST_CYCLES shortened to 8
// Notes:   random pins and answer delays, seed 15
`timescale 1ns/1ns
module tb_reset_cal_sequencer;
  import reset_seq_pkg::*;
  localparam int RC = 8;
  logic ref_clk = 1'b0, rst_n = 1'b0, pdnN = 1'b1, hrstN = 1'b0, pwrIn = 1'b1;
  logic softBit = 1'b0, supGood = 1'b1, calDone;
  logic [1:0] ifSel = 2'h0, addrSel = 2'h0;
  logic [4:0] presets = 5'h0;
  logic [3:0] calDelay = 4'h2;
  logic [6:0] i2cAddress;
  cfg_ctrl_t cfgCtrl;
  out_ctrl_t outCtrl;
  seq_state_t seqState;
  int num_errors = 0, check_count = 0, waited, ldCount = 0;
  always #5 ref_clk = ~ref_clk;
  reset_cal_sequencer #(.RST_CYCLES(RC)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .power_down_input_n(pdnN), .hard_reset_input_n(hrstN), .pin_mode_power_input(pwrIn),
    .ifSelect(ifSel), .presetPins(presets), .addrSelPins(addrSel), .softResetBit(softBit),
    .cfgCtrl(cfgCtrl), .i2cAddress(i2cAddress), .suppliesGood(supGood), .calDone(calDone),
    .outCtrl(outCtrl), .seqState(seqState));
  cal_engine_model partner (.ref_clk(ref_clk), .abort(seqState == ST_RESET || !rst_n),
    .calStart(outCtrl.cal_start), .calDelay(calDelay), .calDone(calDone));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wait_st(seq_state_t s, int n);
    for (waited = 0; waited < n && seqState !== s; waited++) @(negedge ref_clk);
    chk(8'(seqState), 8'(s));
  endtask
  task automatic bring_up(logic expLoad);
    int ld;
    ld = ldCount;
    wait_st(ST_STABILIZE, 4);
    wait_st(ST_CALIBRATE, RC + 8);
    chk(8'(waited >= RC - 2), 8'h1);
    wait_st(ST_RUN, 24);
    chk(8'(ldCount - ld), 8'(expLoad));
    chk(8'(outCtrl.outputs_enabled), 8'h1);
  endtask
  always @(negedge ref_clk) begin
    if (cfgCtrl.load_defaults === 1'b1) ldCount++;
    if (rst_n && seqState inside {ST_STABILIZE, ST_CALIBRATE}) begin
      chk(8'({outCtrl.outputs_reset, outCtrl.outputs_enabled}), 8'h2);
    end
  end
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(15));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (20) @(negedge ref_clk);
    chk(8'({seqState == ST_RESET, outCtrl.outputs_enabled}), 8'h2);
    @(posedge ref_clk);
    hrstN <= 1'b1;
    bring_up(1'b1);
    $display("test power-up done");
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      calDelay <= 4'($urandom);
      ifSel <= 2'(i % 3);
      presets <= 5'($urandom);
      addrSel <= 2'($urandom);
      if (i[0]) pdnN <= 1'b0;
      else hrstN <= 1'b0; // no serial write pending while low
      repeat (3) @(negedge ref_clk);
      chk(8'({seqState == ST_RESET, outCtrl.outputs_enabled}), 8'h2);
      @(posedge ref_clk);
      pdnN <= 1'b1;
      hrstN <= 1'b1;
      bring_up(1'b1);
      chk(8'(cfgCtrl.use_pin_preset), 8'(ifSel == IFSEL_PIN));
      chk(8'(i2cAddress), 8'(7'h54 | 7'(addrSel)));
    end
    $display("test pin resets done");
    @(posedge ref_clk);
    presets <= 5'h1f;
    repeat (3) @(negedge ref_clk);
    chk(8'(cfgCtrl.preset), 8'h1f);
    @(posedge ref_clk);
    pwrIn <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(8'(seqState), 8'(ST_RESET));
    @(posedge ref_clk);
    pwrIn <= 1'b1;
    supGood <= 1'b0;
    wait_st(ST_STABILIZE, 4);
    repeat (RC + 10) @(negedge ref_clk);
    chk(8'(seqState), 8'(ST_STABILIZE));
    @(posedge ref_clk);
    supGood <= 1'b1;
    wait_st(ST_RUN, RC + 30);
    $display("test pin mode and supplies done");
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      softBit <= 1'b1;
      repeat (5) @(negedge ref_clk);
      chk(8'(seqState), 8'(ST_RUN));
      @(posedge ref_clk);
      softBit <= 1'b0;
      calDelay <= 4'hf;
      bring_up(1'b0);
    end
    @(posedge ref_clk);
    softBit <= 1'b1;
    @(posedge ref_clk);
    softBit <= 1'b0;
    wait_st(ST_CALIBRATE, RC + 8);
    @(posedge ref_clk);
    hrstN <= 1'b0; // no serial write pending while low
    repeat (20) @(negedge ref_clk);
    chk(8'(outCtrl.outputs_enabled), 8'h0);
    @(posedge ref_clk);
    hrstN <= 1'b1;
    bring_up(1'b1);
    $display("test soft reset and abort done");
    report_and_stop();
  end
endmodule // tb_reset_cal_sequencer
